// file: src/mic_ctrl.sv
// Interrupt collection, gating, vectoring and wake-up control
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mic_map.svh"
module mic_ctrl
    import mic_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic [`MIC_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   ext_irq_pin,
    input  wire logic [3:0]             port_b_pins,
    input  wire mic_byte_t              timer_zero_count,
    input  wire mic_byte_t              periph_evt_a,
    input  wire mic_byte_t              periph_evt_b,
    input  wire logic                   return_from_irq_instr,
    input  wire logic                   sleep_instr,
    input  wire mic_pc_t                pc_ret,
    output logic                        stack_push,
    output mic_pc_t                     stack_push_pc,
    output logic                        pc_load,
    output mic_pc_t                     pc_load_addr,
    output logic                        cpu_wake,
    output logic                        cpu_asleep,
    output mic_byte_t                   timer_edge_config,
    output logic                        ext_edge_select
);
    mic_flag_if #(.W(3)) ctl_fl ();
    mic_flag_if #(.W(8)) pfa_fl ();
    mic_flag_if #(.W(8)) pfb_fl ();

    logic       ack_r;
    logic       wr_go;
    logic       rd_go;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic       global_irq_enable_r;
    logic       peripheral_master_enable_r;
    logic [2:0] ctl_en_r;
    mic_byte_t  opt_r;
    mic_byte_t  peripheral_irq_enables_a_r;
    mic_byte_t  peripheral_irq_enables_b_r;
    logic       ext_pin_s;
    logic [3:0] port_s;
    logic       ext_prev_r;
    logic [3:0] port_last_r;
    mic_byte_t  tmr_prev_r;
    logic [2:0] settle_r;
    logic       settled;
    logic       ext_edge;
    logic       port_chg;
    logic       tmr_roll;
    logic [1:0] q_r;
    logic       boundary;
    mic_entry_e state_r;
    logic       irq_active;
    logic       take_now;
    logic       wake_now;
    logic       asleep_r;
    logic       wake_r;
    logic       push_r;
    logic       load_r;
    mic_pc_t    push_pc_r;
    mic_pc_t    load_addr_r;

    // Avalon slave: one wait cycle, answer on the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r & avs_byteenable[0];
    assign rd_go = avs_read & ~ack_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        case (avs_address)
            `MIC_REG_CTRL: begin
                rdata_nxt[7:0] = {global_irq_enable_r,
                                  peripheral_master_enable_r,
                                  ctl_en_r, ctl_fl.flags};
            end
            `MIC_REG_OPT:  rdata_nxt[7:0] = opt_r;
            `MIC_REG_PFA:  rdata_nxt[7:0] = pfa_fl.flags;
            `MIC_REG_PFB:  rdata_nxt[7:0] = pfb_fl.flags;
            `MIC_REG_PEA:  rdata_nxt[7:0] = peripheral_irq_enables_a_r;
            `MIC_REG_PEB:  rdata_nxt[7:0] = peripheral_irq_enables_b_r;
            `MIC_REG_STAT: begin
                rdata_nxt[2:0] = {asleep_r, state_r != ENT_IDLE,
                                  irq_active};
            end
            default:       rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (rd_go) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;

    // Enables and edge configuration written by software
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            peripheral_master_enable_r <= 1'b0;
            ctl_en_r                   <= '0;
            opt_r                      <= `MIC_OPT_RST;
            peripheral_irq_enables_a_r <= `MIC_CTRL_RST;
            peripheral_irq_enables_b_r <= `MIC_CTRL_RST;
        end else if (wr_go) begin
            case (avs_address)
                `MIC_REG_CTRL: begin
                    peripheral_master_enable_r <=
                        avs_writedata[`MIC_PERIPHERAL_MASTER_ENABLE_BIT];
                    ctl_en_r <= avs_writedata[`MIC_TIMER_ZERO_OVERFLOW_ENABLE_BIT:`MIC_PORT_CHANGE_ENABLE_BIT];
                end
                `MIC_REG_OPT: opt_r <= avs_writedata[7:0];
                `MIC_REG_PEA: begin
                    peripheral_irq_enables_a_r <=
                        avs_writedata[7:0] & `MIC_PFA_IMPL;
                end
                `MIC_REG_PEB: begin
                    peripheral_irq_enables_b_r <=
                        avs_writedata[7:0] & `MIC_PFB_IMPL;
                end
                default: begin
                end
            endcase
        end
    end

    assign timer_edge_config = opt_r;
    assign ext_edge_select   = opt_r[`MIC_EDGE_BIT];

    // Pins come from outside the clock domain
    mic_sync #(.W(1)) u_sync_ext (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .in_async (ext_irq_pin),
        .stable   (ext_pin_s)
    );
    mic_sync #(.W(4)) u_sync_port (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .in_async (port_b_pins),
        .stable   (port_s)
    );

    // Settling delay stops the reset value of the pins posing as an edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_r    <= '0;
            ext_prev_r  <= 1'b0;
            port_last_r <= '0;
            tmr_prev_r  <= `MIC_TMR_ZERO;
        end else begin
            if (!settled) begin
                settle_r <= settle_r + 3'h1;
            end
            ext_prev_r  <= ext_pin_s;
            port_last_r <= port_s;
            tmr_prev_r  <= timer_zero_count;
        end
    end

    assign settled  = (settle_r == `MIC_SETTLE);
    assign ext_edge = settled & (ext_edge_select ?
                      (ext_pin_s & ~ext_prev_r) : (~ext_pin_s & ext_prev_r));
    assign port_chg = settled & (port_s != port_last_r);
    assign tmr_roll = (tmr_prev_r == `MIC_TMR_MAX) &
                      (timer_zero_count == `MIC_TMR_ZERO);

    // Flag banks: control bits 2..0, then two peripheral banks
    assign ctl_fl.set_ev  = {tmr_roll, ext_edge, port_chg};
    assign ctl_fl.wr_en   = wr_go & (avs_address == `MIC_REG_CTRL);
    assign ctl_fl.wr_data = avs_writedata[2:0];
    assign pfa_fl.set_ev  = periph_evt_a;
    assign pfa_fl.wr_en   = wr_go & (avs_address == `MIC_REG_PFA);
    assign pfa_fl.wr_data = avs_writedata[7:0];
    assign pfb_fl.set_ev  = periph_evt_b;
    assign pfb_fl.wr_en   = wr_go & (avs_address == `MIC_REG_PFB);
    assign pfb_fl.wr_data = avs_writedata[7:0];

    mic_flag_bank #(.W(3), .IMPL(3'h7)) u_ctl_flags (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .fb      (ctl_fl)
    );
    mic_flag_bank #(.W(8), .IMPL(`MIC_PFA_IMPL)) u_pfa_flags (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .fb      (pfa_fl)
    );
    mic_flag_bank #(.W(8), .IMPL(`MIC_PFB_IMPL)) u_pfb_flags (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .fb      (pfb_fl)
    );

    assign irq_active = (|(ctl_fl.flags & ctl_en_r)) |
        (peripheral_master_enable_r &
         ((|(pfa_fl.flags & peripheral_irq_enables_a_r)) |
          (|(pfb_fl.flags & peripheral_irq_enables_b_r))));

    // Instruction cycle phase; requests are taken on its last clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_r <= '0;
        end else begin
            q_r <= boundary ? 2'h0 : q_r + 2'h1;
        end
    end

    assign boundary = (q_r == `MIC_Q_LAST);
    // No wait for a two-cycle instruction, so latency does not depend on it
    assign take_now = boundary & global_irq_enable_r & irq_active &
                      ~asleep_r & (state_r == ENT_IDLE);
    assign wake_now = asleep_r & irq_active;

    // Global enable: accept clears, return sets, software write last
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            global_irq_enable_r <= 1'b0;
        end else if (take_now) begin
            global_irq_enable_r <= 1'b0;
        end else if (return_from_irq_instr) begin
            global_irq_enable_r <= 1'b1;
        end else if (wr_go && avs_address == `MIC_REG_CTRL) begin
            global_irq_enable_r <= avs_writedata[`MIC_GIE_BIT];
        end
    end

    // Entry sequence: push, one flush cycle, then vector fetch
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r     <= ENT_IDLE;
            push_r      <= 1'b0;
            load_r      <= 1'b0;
            push_pc_r   <= `MIC_PC_RST;
            load_addr_r <= `MIC_PC_RST;
        end else begin
            push_r <= 1'b0;
            load_r <= 1'b0;
            case (state_r)
                ENT_IDLE: begin
                    if (take_now) begin
                        state_r   <= ENT_PUSH;
                        push_r    <= 1'b1;
                        push_pc_r <= pc_ret;
                    end
                end
                ENT_PUSH: begin
                    if (boundary) begin
                        state_r <= ENT_FLUSH;
                    end
                end
                ENT_FLUSH: begin
                    if (boundary) begin
                        state_r     <= ENT_IDLE;
                        load_r      <= 1'b1;
                        load_addr_r <= `MIC_VECTOR;
                    end
                end
                default: state_r <= ENT_IDLE;
            endcase
        end
    end

    assign stack_push    = push_r;
    assign stack_push_pc = push_pc_r;
    assign pc_load       = load_r;
    assign pc_load_addr  = load_addr_r;

    // Power-down; a sleep with a request already pending acts as a no-op
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            asleep_r <= 1'b0;
            wake_r   <= 1'b0;
        end else begin
            wake_r <= wake_now;
            if (wake_now) begin
                asleep_r <= 1'b0;
            end else if (sleep_instr && !irq_active) begin
                asleep_r <= 1'b1;
            end
        end
    end

    assign cpu_wake   = wake_r;
    assign cpu_asleep = asleep_r;

    gie_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !global_irq_enable_r |=> !push_r)
        else $error("entry without global enable");
    take_vector_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        take_now |=> push_r && !global_irq_enable_r ##8 load_r &&
        load_addr_r == `MIC_VECTOR)
        else $error("entry sequence wrong");
    take_prompt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        global_irq_enable_r && irq_active && !asleep_r &&
        state_r == ENT_IDLE && !wr_go |-> ##[1:4] push_r)
        else $error("pending interrupt not taken");
    return_from_irq_instr_sets_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        return_from_irq_instr && !take_now |=> global_irq_enable_r)
        else $error("return did not re-enable");
    ext_latency_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ext_edge && global_irq_enable_r && ctl_en_r[1] && !asleep_r &&
        state_r == ENT_IDLE && !wr_go && !sleep_instr |-> ##[9:13] load_r)
        else $error("pin latency out of range");
    ext_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ext_edge |=> ctl_fl.flags[1])
        else $error("pin edge lost");
    edge_pol_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ext_edge |-> (ext_pin_s == ext_edge_select))
        else $error("wrong edge polarity");
    tmr_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(timer_zero_count) == `MIC_TMR_MAX &&
        timer_zero_count == `MIC_TMR_ZERO |=> ctl_fl.flags[2])
        else $error("rollover lost");
    port_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        port_chg |=> ctl_fl.flags[0])
        else $error("port change lost");
    wake_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(wake_r) |-> $past(irq_active) && !asleep_r)
        else $error("wake without cause");
    push_pc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        push_r |-> stack_push_pc == $past(pc_ret))
        else $error("wrong return address");
endmodule

// file: src/mic_map.svh
// Register map, field positions, reset values and timing constants
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH
`define MIC_ADDR_W      5
`define MIC_REG_CTRL    5'h00
`define MIC_REG_OPT     5'h04
`define MIC_REG_PFA     5'h08
`define MIC_REG_PFB     5'h0c
`define MIC_REG_PEA     5'h10
`define MIC_REG_PEB     5'h14
`define MIC_REG_STAT    5'h18
`define MIC_GIE_BIT     3'h7
`define MIC_PERIPHERAL_MASTER_ENABLE_BIT    3'h6
`define MIC_TIMER_ZERO_OVERFLOW_ENABLE_BIT    3'h5
`define MIC_EXT_PIN_ENABLE_BIT    3'h4
`define MIC_PORT_CHANGE_ENABLE_BIT    3'h3
`define MIC_EDGE_BIT    3'h6
`define MIC_CTRL_RST    8'h00
`define MIC_OPT_RST     8'hff
`define MIC_PF_RST      8'h00
`define MIC_PFA_IMPL    8'h77
`define MIC_PFB_IMPL    8'h10
`define MIC_TMR_MAX     8'hff
`define MIC_TMR_ZERO    8'h00
`define MIC_VECTOR      13'h0004
`define MIC_PC_RST      13'h0000
`define MIC_CLK_NS      50
`define MIC_INSTR_NS    200
`define MIC_Q_CNT       ((`MIC_INSTR_NS) / (`MIC_CLK_NS))
`define MIC_Q_LAST      2'(`MIC_Q_CNT - 1)
`define MIC_SETTLE      3'h5
`endif

// file: src/mic_pkg.sv
// Types shared by the interrupt control modules
package mic_pkg;
    typedef enum logic [1:0] {
        ENT_IDLE,
        ENT_PUSH,
        ENT_FLUSH
    } mic_entry_e;
    typedef logic [7:0]  mic_byte_t;
    typedef logic [12:0] mic_pc_t;
endpackage

// file: src/mic_flag_if.sv
// Carrier between the controller and a sticky flag bank
`timescale 1ns/1ps
interface mic_flag_if #(parameter int W = 8);
    logic [W-1:0] set_ev;
    logic         wr_en;
    logic [W-1:0] wr_data;
    logic [W-1:0] flags;
    modport bank (input set_ev, input wr_en, input wr_data, output flags);
    modport ctl  (output set_ev, output wr_en, output wr_data, input flags);
endinterface

// file: src/mic_sync.sv
// Three-stage input synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module mic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] in_async,
    output logic      [W-1:0] stable
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] stable_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= in_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Bitwise agreement filters one-cycle glitches after metastability
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stable_r <= '0;
        end else begin
            stable_r <= (s2_r & s3_r) | (stable_r & (s2_r | s3_r));
        end
    end

    assign stable = stable_r;
endmodule

// file: src/mic_flag_bank.sv
// Sticky flag bank, hardware sets, software writes, set wins
`timescale 1ns/1ps
module mic_flag_bank #(
    parameter int         W    = 8,
    parameter logic [W-1:0] IMPL = '1
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    mic_flag_if.bank  fb
);
    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    always_comb begin
        flags_nxt = fb.wr_en ? fb.wr_data : flags_r;
        flags_nxt = (flags_nxt | fb.set_ev) & IMPL;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign fb.flags = flags_r;

    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !fb.wr_en |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("flag cleared without a write");
    flag_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        1'b1 |=> ((flags_r & $past(fb.set_ev & IMPL))
                  == $past(fb.set_ev & IMPL)))
        else $error("event lost in flag bank");
endmodule

// file: test/mic_core_model.sv
// Behavioural processor core and event counters on the far side
`timescale 1ns/1ps
module mic_core_model
    import mic_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    rstn,
    input  wire logic    do_ret,
    input  wire logic    do_sleep,
    input  wire logic    stack_push,
    input  wire mic_pc_t stack_push_pc,
    input  wire logic    pc_load,
    input  wire mic_pc_t pc_load_addr,
    input  wire logic    cpu_wake,
    input  wire logic    cpu_asleep,
    output logic         return_from_irq_instr,
    output logic         sleep_instr,
    output mic_pc_t      pc_ret,
    output logic [7:0]   push_cnt,
    output logic [7:0]   load_cnt,
    output logic [7:0]   wake_cnt,
    output logic         push_ok,
    output mic_pc_t      last_load
);
    mic_pc_t prev_pc_r;
    // Program counter runs while awake and is frozen in power-down
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc_ret    <= 13'h0100;
            prev_pc_r <= 13'h0100;
        end else begin
            prev_pc_r <= pc_ret;
            if (pc_load) begin
                pc_ret <= pc_load_addr;
            end else if (!cpu_asleep) begin
                pc_ret <= pc_ret + 13'h0001;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            return_from_irq_instr <= 1'h0;
            sleep_instr           <= 1'h0;
        end else begin
            return_from_irq_instr <= do_ret;
            sleep_instr           <= do_sleep;
        end
    end
    // Counted on the falling edge so the bench never races the pulses
    always_ff @(negedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            push_cnt  <= 8'h00;
            load_cnt  <= 8'h00;
            wake_cnt  <= 8'h00;
            push_ok   <= 1'h0;
            last_load <= 13'h0000;
        end else begin
            if (stack_push) begin
                push_cnt <= push_cnt + 8'h01;
                push_ok  <= (stack_push_pc === prev_pc_r);
            end
            if (pc_load) begin
                load_cnt  <= load_cnt + 8'h01;
                last_load <= pc_load_addr;
            end
            if (cpu_wake) begin
                wake_cnt <= wake_cnt + 8'h01;
            end
        end
    end
endmodule

// file: test/mic_ctrl_tb_top.sv
// Self-checking testbench for the interrupt control block
`timescale 1ns/1ps
`include "mic_map.svh"
module mic_ctrl_tb_top
    import mic_pkg::*;
;
    logic        clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, port_b_pins;
    logic        ext_irq_pin, ret_i, slp_i, stack_push, pc_load;
    logic        cpu_wake, cpu_asleep, ext_edge_select, do_ret, do_sleep;
    logic        push_ok;
    mic_byte_t   timer_zero_count, periph_evt_a, periph_evt_b, opt_q;
    mic_byte_t   push_cnt, load_cnt, wake_cnt;
    mic_pc_t     pc_ret, stack_push_pc, pc_load_addr, last_load;
    int          bad_count, compares, ticks;

    mic_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
        .port_b_pins(port_b_pins), .timer_zero_count(timer_zero_count),
        .periph_evt_a(periph_evt_a), .periph_evt_b(periph_evt_b),
        .return_from_irq_instr(ret_i), .sleep_instr(slp_i),
        .pc_ret(pc_ret), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .pc_load(pc_load),
        .pc_load_addr(pc_load_addr), .cpu_wake(cpu_wake),
        .cpu_asleep(cpu_asleep), .timer_edge_config(opt_q),
        .ext_edge_select(ext_edge_select));
    mic_core_model core (.clk_sys(clk_sys), .rstn(rstn), .do_ret(do_ret),
        .do_sleep(do_sleep), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .pc_load(pc_load),
        .pc_load_addr(pc_load_addr), .cpu_wake(cpu_wake),
        .cpu_asleep(cpu_asleep), .return_from_irq_instr(ret_i),
        .sleep_instr(slp_i), .pc_ret(pc_ret), .push_cnt(push_cnt),
        .load_cnt(load_cnt), .wake_cnt(wake_cnt), .push_ok(push_ok),
        .last_load(last_load));

    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_reg(input mic_byte_t got, input mic_byte_t exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pc(input mic_pc_t got, input mic_pc_t exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Request held until waitrequest is seen low, data taken then
    task automatic wait_ack(output mic_byte_t d);
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge clk_sys);
        end
        d = avs_readdata[7:0];
    endtask
    task automatic av_write(input logic [4:0] a, input mic_byte_t d);
        mic_byte_t x;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write     <= 1'h1;
        wait_ack(x);
        avs_write <= 1'h0;
    endtask
    task automatic av_read(input logic [4:0] a, output mic_byte_t d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read    <= 1'h1;
        wait_ack(d);
        avs_read <= 1'h0;
    endtask
    task automatic chk(input logic [4:0] a, input mic_byte_t e);
        mic_byte_t r;
        av_read(a, r);
        cmp_reg(r, e);
    endtask
    task automatic pulse_sleep();
        @(posedge clk_sys);
        do_sleep <= 1'h1;
        @(posedge clk_sys);
        do_sleep <= 1'h0;
        cyc(3);
    endtask
    task automatic fire(input int s);
        @(posedge clk_sys);
        case (s)
            0: timer_zero_count <= 8'hff;
            1: ext_irq_pin <= ~ext_irq_pin;
            2: port_b_pins[2] <= ~port_b_pins[2];
            3: periph_evt_a <= 8'h01;
            default: periph_evt_b <= 8'h10;
        endcase
        @(posedge clk_sys);
        timer_zero_count <= 8'h00;
        periph_evt_a     <= 8'h00;
        periph_evt_b     <= 8'h00;
        cyc(8);
    endtask
    task automatic t_reset();
        logic [4:0] a [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14,
                              5'h18};
        mic_byte_t  e [7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00};
        for (int i = 0; i < 7; i++) begin
            chk(a[i], e[i]);
        end
        cmp_flag(ext_edge_select, 1'h1);
        av_write(5'h1c, 8'h5a);
        avs_byteenable <= 4'he;
        av_write(`MIC_REG_CTRL, 8'h80);
        avs_byteenable <= 4'hf;
        chk(5'h1c, 8'h00);
        chk(`MIC_REG_CTRL, 8'h00);
    endtask
    // Flag sets with the global and CTRL enables shut, then each is opened in turn
    task automatic t_gate(input int s, input mic_byte_t fl,
                          input mic_byte_t en);
        mic_byte_t p0;
        av_write(`MIC_REG_CTRL, 8'h00);
        av_write(`MIC_REG_PFA, 8'h00);
        av_write(`MIC_REG_PFB, 8'h00);
        fire(s);
        chk(`MIC_REG_CTRL, fl);
        chk(`MIC_REG_PFA, (s == 3) ? 8'h01 : 8'h00);
        chk(`MIC_REG_PFB, (s == 4) ? 8'h10 : 8'h00);
        p0 = push_cnt;
        av_write(`MIC_REG_CTRL, 8'h80 | fl);
        cyc(20);
        cmp_reg(push_cnt, p0);
        av_write(`MIC_REG_CTRL, 8'h80 | fl | en);
        p0 = load_cnt;
        for (int k = 0; k < 16 && load_cnt == p0; k++) begin
            @(posedge clk_sys);
        end
        cmp_reg(load_cnt, p0 + 8'h01);
        cmp_flag(push_ok, 1'h1);
        cmp_pc(last_load, `MIC_VECTOR);
        chk(`MIC_REG_CTRL, fl | en);
    endtask
    task automatic t_edge();
        av_write(`MIC_REG_OPT, 8'hbf);
        cyc(1);
        cmp_flag(ext_edge_select, 1'h0);
        cmp_reg(opt_q, 8'hbf);
        av_write(`MIC_REG_CTRL, 8'h00);
        fire(1);
        chk(`MIC_REG_CTRL, 8'h02);
        av_write(`MIC_REG_CTRL, 8'h00);
        fire(1);
        chk(`MIC_REG_CTRL, 8'h00);
        av_write(`MIC_REG_OPT, 8'hff);
    endtask
    task automatic t_ret();
        mic_byte_t p0;
        av_write(`MIC_REG_PFB, 8'h00);
        av_write(`MIC_REG_CTRL, 8'h10);
        p0 = push_cnt;
        @(posedge clk_sys);
        do_ret <= 1'h1;
        @(posedge clk_sys);
        do_ret <= 1'h0;
        cyc(20);
        chk(`MIC_REG_CTRL, 8'h90);
        cmp_reg(push_cnt, p0);
        fire(1);
        fire(1);
        cyc(12);
        cmp_reg(push_cnt, p0 + 8'h01);
        @(posedge clk_sys);
        rstn <= 1'h0;
        cyc(2);
        rstn <= 1'h1;
        cyc(4);
        chk(`MIC_REG_CTRL, 8'h00);
        chk(`MIC_REG_OPT, 8'hff);
    endtask
    task automatic t_sleep(input logic g);
        mic_byte_t w0, l0;
        av_write(`MIC_REG_CTRL, g ? 8'h90 : 8'h10);
        @(posedge clk_sys);
        ext_irq_pin <= 1'h0;
        cyc(8);
        pulse_sleep();
        cmp_flag(cpu_asleep, 1'h1);
        w0 = wake_cnt;
        l0 = load_cnt;
        fire(1);
        cyc(20);
        cmp_reg(wake_cnt, w0 + 8'h01);
        cmp_flag(cpu_asleep, 1'h0);
        cmp_reg(load_cnt, l0 + {7'h00, g});
        cmp_pc(last_load, g ? `MIC_VECTOR : 13'h0000);
        chk(`MIC_REG_CTRL, 8'h12);
    endtask
    task automatic t_nowake();
        av_write(`MIC_REG_CTRL, 8'h00);
        @(posedge clk_sys);
        ext_irq_pin <= 1'h0;
        cyc(8);
        pulse_sleep();
        fire(1);
        cyc(10);
        cmp_flag(cpu_asleep, 1'h1);
        av_write(`MIC_REG_CTRL, 8'h12);
        cyc(3);
        cmp_flag(cpu_asleep, 1'h0);
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Ceiling well above the several hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        ticks++;
        if (ticks == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        {bad_count, compares, ticks} = '0;
        {avs_read, avs_write, ext_irq_pin, do_ret, do_sleep} = '0;
        {avs_address, avs_writedata, port_b_pins} = '0;
        {periph_evt_a, periph_evt_b} = '0;
        timer_zero_count = 8'h10;
        avs_byteenable   = 4'hf;
        rstn             = 1'h0;
        cyc(2);
        rstn <= 1'h1;
        cyc(4);
        t_reset();
        av_write(`MIC_REG_PEA, 8'h01);
        av_write(`MIC_REG_PEB, 8'h10);
        t_gate(0, 8'h04, 8'h20);
        t_gate(1, 8'h02, 8'h10);
        t_gate(2, 8'h01, 8'h08);
        t_gate(3, 8'h00, 8'h40);
        t_gate(4, 8'h00, 8'h40);
        t_edge();
        t_ret();
        t_sleep(1'h0);
        t_sleep(1'h1);
        t_nowake();
        report_and_stop();
    end
endmodule
